// File: common/iop_pkg.sv
package iop_pkg;

	// port widths
	localparam int P0_W = 6;
	localparam int P1_W = 8;
	localparam int P2_W = 6;
	localparam int P3_W = 5;
	localparam int P4_W = 8;
	localparam int P89_W = 8;
	localparam int P12_W = 1;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;

	////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses on the register port)
	localparam logic [7:0] OFS_P0 = 8'h00;
	localparam logic [7:0] OFS_P1 = 8'h01;
	localparam logic [7:0] OFS_P2 = 8'h02;
	localparam logic [7:0] OFS_P3 = 8'h03;
	localparam logic [7:0] OFS_P4 = 8'h04;
	localparam logic [7:0] OFS_P8 = 8'h08;
	localparam logic [7:0] OFS_P9 = 8'h09;
	localparam logic [7:0] OFS_P12 = 8'h0c;
	localparam logic [7:0] OFS_DIR0 = 8'h20;
	localparam logic [7:0] OFS_DIR2 = 8'h22;
	localparam logic [7:0] OFS_DIR3 = 8'h23;
	localparam logic [7:0] OFS_DIR4 = 8'h24;
	localparam logic [7:0] OFS_DIR12 = 8'h2c;
	localparam logic [7:0] OFS_PU0 = 8'h30;
	localparam logic [7:0] OFS_PU2 = 8'h32;
	localparam logic [7:0] OFS_PU3 = 8'h33;
	localparam logic [7:0] OFS_PU4 = 8'h34;
	localparam logic [7:0] OFS_PU12 = 8'h3c;
	localparam logic [7:0] OFS_KRSW = 8'h40;
	localparam logic [7:0] OFS_MEMX = 8'h41;
	localparam logic [7:0] OFS_KRFLAG = 8'h42;
	localparam logic [7:0] OFS_P0FLAG = 8'h43;

	////////////////////////////////////////////////////////////////////////
	// field positions and values after reset
	localparam int KR_WIDTH_BIT = 0;
	localparam int KR_FLAG_BIT = 0;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hff;
	localparam logic [7:0] PU_RST = 8'h00;
	localparam logic [7:0] MEMX_RST = 8'h00;
	localparam logic [7:0] MEMX_KR_ON = 8'h01;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [7:0] KR_PREV_RST = 8'h00;

endpackage

// File: core/iop_bidir_port.sv
// one bidirectional port: output latch, direction and pull-up option bits
module iop_bidir_port #(
	parameter int W = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_latch,
	input wire logic wr_dir,
	input wire logic wr_pu,
	input wire logic [W-1:0] wdata,
	input wire logic [W-1:0] pin_in,
	input wire logic [W-1:0] alt_out,
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe,
	output logic [W-1:0] pu_en,
	output logic [W-1:0] rd_val,
	output logic [W-1:0] dir_val,
	output logic [W-1:0] pu_val
);

	typedef struct packed {
		logic [W-1:0] latch;
		logic [W-1:0] dir;
		logic [W-1:0] pu;
	} iop_bidir_s;

	iop_bidir_s st_reg;
	iop_bidir_s st_next;

	////////////////////////////////////////////////////////////////////////
	// register writes
	always_comb
	begin
		st_next = st_reg;
		if (wr_latch)
			st_next.latch = wdata;
		if (wr_dir)
			st_next.dir = wdata;
		if (wr_pu)
			st_next.pu = wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_reg.latch <= iop_pkg::LATCH_RST[W-1:0];
			st_reg.dir <= iop_pkg::DIR_RST[W-1:0];
			st_reg.pu <= iop_pkg::PU_RST[W-1:0];
		end
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////
	// drive latch when direction is 0
	// alternate output is or-ed in, so software must park the latch at 0
	assign pin_oe = ~st_reg.dir;
	assign pin_out = st_reg.latch | alt_out;
	// read pin level in input mode, latch in output mode
	assign rd_val = (st_reg.dir & pin_in) | (~st_reg.dir & st_reg.latch);
	assign pu_en = st_reg.pu & st_reg.dir;
	assign dir_val = st_reg.dir;
	assign pu_val = st_reg.pu;

	////////////////////////////////////////////////////////////////////////
	// direction after reset
	dir_reset_a: assert property (
		@(posedge clk_sys) rst |=> (pin_oe == '0) && (pu_en == '0))
		else $error("port not in input mode after reset");

	dir_write_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wr_dir |=> pin_oe == ~$past(wdata))
		else $error("pin enable does not follow direction write");

	pullup_mode_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wr_pu && !wr_dir |=> pu_en == ($past(wdata) & ~pin_oe))
		else $error("pull-up enable wrong for pin mode");

endmodule // iop_bidir_port

// File: core/iop_kr_detect.sv
// falling-edge detector on the key-return pins
module iop_kr_detect (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic enable,
	input wire logic width_sel8,
	input wire logic [7:0] pins,
	output logic fall
);

	typedef struct packed {
		logic [7:0] prev;
	} iop_kr_s;

	iop_kr_s st_reg;
	iop_kr_s st_next;
	logic [7:0] mask;

	assign mask = width_sel8 ? 8'hff : 8'h0f;
	// high then low is a falling edge
	assign fall = enable && |(st_reg.prev & ~pins & mask);

	always_comb
	begin
		st_next.prev = pins;
	end

	// prev resets low: a key already low at reset gives no false edge,
	// at the cost of missing a press in the very first cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			st_reg.prev <= iop_pkg::KR_PREV_RST;
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////
	// upper pins ignored in four-pin mode
	kr_width_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!width_sel8 && pins[3:0] == 4'hf && $past(pins[3:0]) == 4'hf
		|-> !fall)
		else $error("upper pin edge seen in four-pin mode");

	// a low edge on pin 0 is caught
	kr_edge_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		enable && pins[0] ##1 enable && !pins[0] |-> fall)
		else $error("falling edge on pin 0 missed");

endmodule // iop_kr_detect

// File: core/iop_io_port_bank.sv
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - port 0: six I/O pins, latch, per-bit direction register
// - port 2: six I/O pins, latch, per-bit direction register
// - port 3: five I/O pins, latch, per-bit direction register
// - port 4: eight I/O pins, latch, per-bit direction register
// - port 1: eight input-only pins, readable, no latch or direction
// - ports 8 and 9: eight output-only pins, driving from reset
// - port 12: one I/O pin, direction, pull-up option, input after reset
// - each I/O pin has its own software pull-up enable bit
// - reset puts ports 0, 2, 3, 4 into input mode
// - port 0 pins double as interrupt, trigger, clock, buzzer signals
// - port 0 output level change sets its interrupt request flag
// - port 1 pins double as converter analog inputs
// - port 2 carries serial signals, port 3 timer signals
// - falling edge on a watched port 4 pin sets key-return flag
// - switch register bit 0 selects four or eight watched pins
// - reset loads every direction register with all ones
module iop_io_port_bank (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [5:0] p0_in,
	input wire logic [5:0] p0_alt_out,
	output logic [5:0] p0_out,
	output logic [5:0] p0_oe,
	output logic [5:0] p0_pu,
	output logic [5:0] p0_irq_flag,
	input wire logic [7:0] p1_in,
	output logic [7:0] p1_analog,
	input wire logic [5:0] p2_in,
	input wire logic [5:0] p2_alt_out,
	output logic [5:0] p2_out,
	output logic [5:0] p2_oe,
	output logic [5:0] p2_pu,
	input wire logic [4:0] p3_in,
	input wire logic [4:0] p3_alt_out,
	output logic [4:0] p3_out,
	output logic [4:0] p3_oe,
	output logic [4:0] p3_pu,
	input wire logic [7:0] p4_in,
	output logic [7:0] p4_out,
	output logic [7:0] p4_oe,
	output logic [7:0] p4_pu,
	output logic [7:0] p8_out,
	output logic [7:0] p8_oe,
	output logic [7:0] p9_out,
	output logic [7:0] p9_oe,
	input wire logic [0:0] p12_in,
	input wire logic [0:0] p12_alt_out,
	output logic [0:0] p12_out,
	output logic [0:0] p12_oe,
	output logic [0:0] p12_pu,
	output logic key_return_irq_flag
);

	typedef struct packed {
		logic [7:0] p8_latch;
		logic [7:0] p9_latch;
		logic key_return_width_select;
		logic [7:0] mem_expansion;
		logic kr_flag;
		logic [5:0] p0_flag;
		logic [5:0] p0_drv_prev;
		logic [5:0] p0_oe_prev;
		logic [7:0] rdata;
	} iop_bank_s;

	iop_bank_s st_reg;
	iop_bank_s st_next;

	// address match shared by every write and read decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	logic [5:0] p0_rd, p0_dir, p0_puv;
	logic [5:0] p2_rd, p2_dir, p2_puv;
	logic [4:0] p3_rd, p3_dir, p3_puv;
	logic [7:0] p4_rd, p4_dir, p4_puv;
	logic [0:0] p12_rd, p12_dir, p12_puv;
	logic [5:0] p0_change;
	logic kr_fall;
	logic kr_on;
	logic [7:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// port 0, alternate outputs are clock and buzzer
	iop_bidir_port #(.W(iop_pkg::P0_W)) u_port0 (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_latch(reg_wr && hit(reg_addr, iop_pkg::OFS_P0)),
		.wr_dir(reg_wr && hit(reg_addr, iop_pkg::OFS_DIR0)),
		.wr_pu(reg_wr && hit(reg_addr, iop_pkg::OFS_PU0)),
		.wdata(reg_wdata[5:0]),
		.pin_in(p0_in),
		.alt_out(p0_alt_out),
		.pin_out(p0_out),
		.pin_oe(p0_oe),
		.pu_en(p0_pu),
		.rd_val(p0_rd),
		.dir_val(p0_dir),
		.pu_val(p0_puv)
	);

	// port 2, serial data and clock share these pins
	iop_bidir_port #(.W(iop_pkg::P2_W)) u_port2 (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_latch(reg_wr && hit(reg_addr, iop_pkg::OFS_P2)),
		.wr_dir(reg_wr && hit(reg_addr, iop_pkg::OFS_DIR2)),
		.wr_pu(reg_wr && hit(reg_addr, iop_pkg::OFS_PU2)),
		.wdata(reg_wdata[5:0]),
		.pin_in(p2_in),
		.alt_out(p2_alt_out),
		.pin_out(p2_out),
		.pin_oe(p2_oe),
		.pu_en(p2_pu),
		.rd_val(p2_rd),
		.dir_val(p2_dir),
		.pu_val(p2_puv)
	);

	// port 3, timer outputs share these pins
	iop_bidir_port #(.W(iop_pkg::P3_W)) u_port3 (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_latch(reg_wr && hit(reg_addr, iop_pkg::OFS_P3)),
		.wr_dir(reg_wr && hit(reg_addr, iop_pkg::OFS_DIR3)),
		.wr_pu(reg_wr && hit(reg_addr, iop_pkg::OFS_PU3)),
		.wdata(reg_wdata[4:0]),
		.pin_in(p3_in),
		.alt_out(p3_alt_out),
		.pin_out(p3_out),
		.pin_oe(p3_oe),
		.pu_en(p3_pu),
		.rd_val(p3_rd),
		.dir_val(p3_dir),
		.pu_val(p3_puv)
	);

	iop_bidir_port #(.W(iop_pkg::P4_W)) u_port4 (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_latch(reg_wr && hit(reg_addr, iop_pkg::OFS_P4)),
		.wr_dir(reg_wr && hit(reg_addr, iop_pkg::OFS_DIR4)),
		.wr_pu(reg_wr && hit(reg_addr, iop_pkg::OFS_PU4)),
		.wdata(reg_wdata),
		.pin_in(p4_in),
		.alt_out(8'h00),
		.pin_out(p4_out),
		.pin_oe(p4_oe),
		.pu_en(p4_pu),
		.rd_val(p4_rd),
		.dir_val(p4_dir),
		.pu_val(p4_puv)
	);

	iop_bidir_port #(.W(iop_pkg::P12_W)) u_port12 (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_latch(reg_wr && hit(reg_addr, iop_pkg::OFS_P12)),
		.wr_dir(reg_wr && hit(reg_addr, iop_pkg::OFS_DIR12)),
		.wr_pu(reg_wr && hit(reg_addr, iop_pkg::OFS_PU12)),
		.wdata(reg_wdata[0:0]),
		.pin_in(p12_in),
		.alt_out(p12_alt_out),
		.pin_out(p12_out),
		.pin_oe(p12_oe),
		.pu_en(p12_pu),
		.rd_val(p12_rd),
		.dir_val(p12_dir),
		.pu_val(p12_puv)
	);

	////////////////////////////////////////////////////////////////////////
	// key-return detector only runs once memory expansion is set up
	assign kr_on = (st_reg.mem_expansion == iop_pkg::MEMX_KR_ON);

	iop_kr_detect u_kr (
		.clk_sys(clk_sys),
		.rst(rst),
		.enable(kr_on),
		.width_sel8(st_reg.key_return_width_select),
		.pins(p4_in),
		.fall(kr_fall)
	);

	// driven level moved on a pin held in output mode
	assign p0_change = p0_oe & st_reg.p0_oe_prev & (p0_out ^ st_reg.p0_drv_prev);

	////////////////////////////////////////////////////////////////////////
	// register readback, unmapped offsets read zero
	always_comb
	begin
		unique case (1'b1)
			hit(reg_addr, iop_pkg::OFS_P0): rd_mux = {2'h0, p0_rd};
			hit(reg_addr, iop_pkg::OFS_P1): rd_mux = p1_in;
			hit(reg_addr, iop_pkg::OFS_P2): rd_mux = {2'h0, p2_rd};
			hit(reg_addr, iop_pkg::OFS_P3): rd_mux = {3'h0, p3_rd};
			hit(reg_addr, iop_pkg::OFS_P4): rd_mux = p4_rd;
			hit(reg_addr, iop_pkg::OFS_P8): rd_mux = st_reg.p8_latch;
			hit(reg_addr, iop_pkg::OFS_P9): rd_mux = st_reg.p9_latch;
			hit(reg_addr, iop_pkg::OFS_P12): rd_mux = {7'h00, p12_rd};
			// unused direction bits read as one
			hit(reg_addr, iop_pkg::OFS_DIR0): rd_mux = {2'h3, p0_dir};
			hit(reg_addr, iop_pkg::OFS_DIR2): rd_mux = {2'h3, p2_dir};
			hit(reg_addr, iop_pkg::OFS_DIR3): rd_mux = {3'h7, p3_dir};
			hit(reg_addr, iop_pkg::OFS_DIR4): rd_mux = p4_dir;
			hit(reg_addr, iop_pkg::OFS_DIR12): rd_mux = {7'h7f, p12_dir};
			hit(reg_addr, iop_pkg::OFS_PU0): rd_mux = {2'h0, p0_puv};
			hit(reg_addr, iop_pkg::OFS_PU2): rd_mux = {2'h0, p2_puv};
			hit(reg_addr, iop_pkg::OFS_PU3): rd_mux = {3'h0, p3_puv};
			hit(reg_addr, iop_pkg::OFS_PU4): rd_mux = p4_puv;
			hit(reg_addr, iop_pkg::OFS_PU12): rd_mux = {7'h00, p12_puv};
			hit(reg_addr, iop_pkg::OFS_KRSW):
				rd_mux = {7'h00, st_reg.key_return_width_select};
			hit(reg_addr, iop_pkg::OFS_MEMX): rd_mux = st_reg.mem_expansion;
			hit(reg_addr, iop_pkg::OFS_KRFLAG): rd_mux = {7'h00, st_reg.kr_flag};
			hit(reg_addr, iop_pkg::OFS_P0FLAG): rd_mux = {2'h0, st_reg.p0_flag};
			default: rd_mux = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state: own registers, flags and read data
	always_comb
	begin
		st_next = st_reg;
		st_next.p0_drv_prev = p0_out;
		st_next.p0_oe_prev = p0_oe;
		st_next.rdata = reg_rd ? rd_mux : iop_pkg::RDATA_RST;
		if (reg_wr && hit(reg_addr, iop_pkg::OFS_P8))
			st_next.p8_latch = reg_wdata;
		if (reg_wr && hit(reg_addr, iop_pkg::OFS_P9))
			st_next.p9_latch = reg_wdata;
		if (reg_wr && hit(reg_addr, iop_pkg::OFS_KRSW))
			st_next.key_return_width_select =
				reg_wdata[iop_pkg::KR_WIDTH_BIT];
		if (reg_wr && hit(reg_addr, iop_pkg::OFS_MEMX))
			st_next.mem_expansion = reg_wdata;
		// write-one clears; a new event in the same cycle wins
		if (reg_wr && hit(reg_addr, iop_pkg::OFS_KRFLAG))
			st_next.kr_flag = st_reg.kr_flag & ~reg_wdata[iop_pkg::KR_FLAG_BIT];
		if (reg_wr && hit(reg_addr, iop_pkg::OFS_P0FLAG))
			st_next.p0_flag = st_reg.p0_flag & ~reg_wdata[5:0];
		if (kr_fall)
			st_next.kr_flag = 1'b1;
		// output level change sets port 0 flag
		st_next.p0_flag = st_next.p0_flag | p0_change;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_reg.p8_latch <= iop_pkg::LATCH_RST;
			st_reg.p9_latch <= iop_pkg::LATCH_RST;
			st_reg.key_return_width_select <= 1'b0;
			st_reg.mem_expansion <= iop_pkg::MEMX_RST;
			st_reg.kr_flag <= 1'b0;
			st_reg.p0_flag <= 6'h00;
			st_reg.p0_drv_prev <= 6'h00;
			st_reg.p0_oe_prev <= 6'h00;
			st_reg.rdata <= iop_pkg::RDATA_RST;
		end
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	// ports 8 and 9 always drive
	assign p8_out = st_reg.p8_latch;
	assign p8_oe = 8'hff;
	assign p9_out = st_reg.p9_latch;
	assign p9_oe = 8'hff;
	// analog path is the raw pin level
	assign p1_analog = p1_in;
	assign p0_irq_flag = st_reg.p0_flag;
	assign key_return_irq_flag = st_reg.kr_flag;
	assign reg_rdata = st_reg.rdata;

	////////////////////////////////////////////////////////////////////////
	// port 1 read one cycle later
	p1_read_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		reg_rd && reg_addr == iop_pkg::OFS_P1 |=> reg_rdata == $past(p1_in))
		else $error("port 1 read data wrong");

	p0_irq_set_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		p0_oe[0] ##1 p0_oe[0] && $changed(p0_out[0]) ##1 1'b1
		|-> p0_irq_flag[0])
		else $error("port 0 output change did not set flag");

	// edge sets flag, not lost to clear
	kr_flag_set_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		kr_fall |=> key_return_irq_flag)
		else $error("key-return flag not set after edge");

	// all five bidirectional ports input after reset
	port_input_rst_a: assert property (
		@(posedge clk_sys) rst |=> p0_oe == 6'h00 && p2_oe == 6'h00
			&& p3_oe == 5'h00 && p4_oe == 8'h00 && p12_oe == 1'b0)
		else $error("bidirectional port driving after reset");

	p89_drive_a: assert property (
		@(posedge clk_sys) p8_oe == 8'hff && p9_oe == 8'hff)
		else $error("output-only port released");

endmodule // iop_io_port_bank

// File: tb/iop_pin_model.sv
// board side of one bidirectional port: external drivers and pull-ups
module iop_pin_model #(
	parameter int W = 8
) (
	input wire logic clk_sys,
	input wire logic [W-1:0] drv_out,
	input wire logic [W-1:0] drv_oe,
	input wire logic [W-1:0] pu_on,
	input wire logic [W-1:0] ext_val,
	input wire logic [W-1:0] ext_en,
	output logic [W-1:0] level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [W-1:0] last_reg;

	////////////////////////////////////////////////////////////////////////
	// pin resolution
	// an undriven pin without pull-up wanders instead of holding its level
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			if (drv_oe[i])
				level[i] = drv_out[i];
			else if (ext_en[i])
				level[i] = ext_val[i];
			else if (pu_on[i])
				level[i] = 1'h1;
			else
				level[i] = ~last_reg[i];
		end
	end

	// history for the floating pattern
	always_ff @(posedge clk_sys)
		last_reg <= level;
endmodule // iop_pin_model

// File: tb/iop_io_port_bank_test.sv
module iop_io_port_bank_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic reg_wr = 1'h0, reg_rd = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [7:0] ext_v = 8'hc3, ext_en = 8'hff, p1_in = 8'h00, p1_analog;
	logic [5:0] p0_in, p0_out, p0_oe, p0_pu, p0_irq_flag, p0_alt = 6'h00;
	logic [5:0] p2_in, p2_out, p2_oe, p2_pu, p2_alt = 6'h00;
	logic [4:0] p3_in, p3_out, p3_oe, p3_pu, p3_alt = 5'h04;
	logic [7:0] p4_in, p4_out, p4_oe, p4_pu, p8_out, p8_oe, p9_out, p9_oe;
	logic [0:0] p12_in, p12_out, p12_oe, p12_pu, p12_alt = 1'h0;
	logic kr_flag;
	int errors = 0;
	int comparisons = 0;
	logic [7:0] ofs_port [5] = '{iop_pkg::OFS_P0, iop_pkg::OFS_P2,
		iop_pkg::OFS_P3, iop_pkg::OFS_P4, iop_pkg::OFS_P12};
	logic [7:0] ofs_dir [5] = '{iop_pkg::OFS_DIR0, iop_pkg::OFS_DIR2,
		iop_pkg::OFS_DIR3, iop_pkg::OFS_DIR4, iop_pkg::OFS_DIR12};
	logic [7:0] ofs_pu [5] = '{iop_pkg::OFS_PU0, iop_pkg::OFS_PU2,
		iop_pkg::OFS_PU3, iop_pkg::OFS_PU4, iop_pkg::OFS_PU12};
	logic [7:0] mask [5] = '{8'h3f, 8'h3f, 8'h1f, 8'hff, 8'h01};

	// 250 MHz system clock
	always #2 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////
	iop_io_port_bank dut (.clk_sys(clk_sys), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .p0_in(p0_in),
		.p0_alt_out(p0_alt), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pu(p0_pu),
		.p0_irq_flag(p0_irq_flag), .p1_in(p1_in), .p1_analog(p1_analog),
		.p2_in(p2_in), .p2_alt_out(p2_alt), .p2_out(p2_out), .p2_oe(p2_oe),
		.p2_pu(p2_pu), .p3_in(p3_in), .p3_alt_out(p3_alt), .p3_out(p3_out),
		.p3_oe(p3_oe), .p3_pu(p3_pu), .p4_in(p4_in), .p4_out(p4_out),
		.p4_oe(p4_oe), .p4_pu(p4_pu), .p8_out(p8_out), .p8_oe(p8_oe),
		.p9_out(p9_out), .p9_oe(p9_oe), .p12_in(p12_in),
		.p12_alt_out(p12_alt), .p12_out(p12_out), .p12_oe(p12_oe),
		.p12_pu(p12_pu), .key_return_irq_flag(kr_flag));

	// board side of each bidirectional port, sharing one external pattern
	iop_pin_model #(.W(6)) pins_a (.clk_sys(clk_sys), .drv_out(p0_out),
		.drv_oe(p0_oe), .pu_on(p0_pu), .ext_val(ext_v[5:0]),
		.ext_en(ext_en[5:0]), .level(p0_in));
	iop_pin_model #(.W(6)) pins_b (.clk_sys(clk_sys), .drv_out(p2_out),
		.drv_oe(p2_oe), .pu_on(p2_pu), .ext_val(ext_v[5:0]),
		.ext_en(ext_en[5:0]), .level(p2_in));
	iop_pin_model #(.W(5)) pins_c (.clk_sys(clk_sys), .drv_out(p3_out),
		.drv_oe(p3_oe), .pu_on(p3_pu), .ext_val(ext_v[4:0]),
		.ext_en(ext_en[4:0]), .level(p3_in));
	iop_pin_model #(.W(8)) pins_d (.clk_sys(clk_sys), .drv_out(p4_out),
		.drv_oe(p4_oe), .pu_on(p4_pu), .ext_val(ext_v),
		.ext_en(ext_en), .level(p4_in));
	iop_pin_model #(.W(1)) pins_e (.clk_sys(clk_sys), .drv_out(p12_out),
		.drv_oe(p12_oe), .pu_on(p12_pu), .ext_val(ext_v[0:0]),
		.ext_en(ext_en[0:0]), .level(p12_in));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1;
		chk($sformatf("read %h", a), reg_rdata, exp);
	endtask

	// high pattern settles first so the detector sees a clean edge
	task automatic fall(input logic [7:0] v, input logic exp);
		@(posedge clk_sys);
		ext_v <= 8'hff;
		repeat (3) @(posedge clk_sys);
		ext_v <= v;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("key_return_irq_flag", {7'h00, kr_flag}, {7'h00, exp});
	endtask

	task automatic complete_run();
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog against a stalled sequence
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		#1;
		chk("p8_oe", p8_oe, 8'hff);
		chk("p9_oe", p9_oe, 8'hff);
		chk("p9_out", p9_out, 8'h00);
		chk("p4_oe", p4_oe, 8'h00);
		chk("p12_oe", {7'h00, p12_oe}, 8'h00);
		// reset state of every bidirectional port, pins read back
		for (int i = 0; i < 5; i++)
		begin
			rd(ofs_dir[i], 8'hff);
			rd(ofs_pu[i], 8'h00);
			rd(ofs_port[i], 8'hc3 & mask[i]);
		end
		// low nibble driven from the latch, high nibble from the pins
		for (int i = 0; i < 5; i++)
		begin
			wr(ofs_port[i], 8'h5a);
			wr(ofs_dir[i], 8'hf0);
			rd(ofs_port[i], 8'hca & mask[i]);
			rd(ofs_dir[i], 8'hf0 | ~mask[i]);
		end
		chk("p4_oe", p4_oe, 8'h0f);
		chk("p4_out", p4_out, 8'h5a);
		chk("p2_oe", {2'h0, p2_oe}, 8'h0f);
		chk("p2_out", {2'h0, p2_out}, 8'h1a);
		// latch bit 2 parked at 0 so the timer output shows through
		chk("p3_out", {3'h0, p3_out}, 8'h1e);
		chk("p3_oe", {3'h0, p3_oe}, 8'h0f);
		chk("p0_oe", {2'h0, p0_oe}, 8'h0f);
		chk("p12_oe", {7'h00, p12_oe}, 8'h01);
		chk("p12_out", {7'h00, p12_out}, 8'h00);
		// every port back to input, all pull-ups on
		for (int i = 0; i < 5; i++)
		begin
			wr(ofs_dir[i], 8'hff);
			wr(ofs_pu[i], 8'hff);
			rd(ofs_pu[i], mask[i]);
		end
		chk("p0_pu", {2'h0, p0_pu}, 8'h3f);
		chk("p2_pu", {2'h0, p2_pu}, 8'h3f);
		chk("p3_pu", {3'h0, p3_pu}, 8'h1f);
		chk("p12_pu", {7'h00, p12_pu}, 8'h01);
		// pull-up only on an input pin
		ext_en <= 8'h00;
		rd(iop_pkg::OFS_P4, 8'hff);
		chk("p4_pu", p4_pu, 8'hff);
		wr(iop_pkg::OFS_DIR4, 8'h00);
		chk("p4_pu", p4_pu, 8'h00);
		wr(iop_pkg::OFS_DIR4, 8'hff);
		wr(iop_pkg::OFS_PU4, 8'h00);
		ext_en <= 8'hff;
		// input-only port ignores writes
		p1_in <= 8'h96;
		wr(iop_pkg::OFS_P1, 8'h00);
		rd(iop_pkg::OFS_P1, 8'h96);
		chk("p1_analog", p1_analog, 8'h96);
		wr(iop_pkg::OFS_P8, 8'h3c);
		wr(iop_pkg::OFS_P9, 8'hc3);
		chk("p8_out", p8_out, 8'h3c);
		rd(iop_pkg::OFS_P9, 8'hc3);
		rd(8'h7f, 8'h00);
		// driven level change on port 0 raises its flag
		wr(iop_pkg::OFS_P0, 8'h00);
		wr(iop_pkg::OFS_DIR0, 8'h00);
		chk("p0_pu", {2'h0, p0_pu}, 8'h00);
		wr(iop_pkg::OFS_P0FLAG, 8'h3f);
		rd(iop_pkg::OFS_P0FLAG, 8'h00);
		wr(iop_pkg::OFS_P0, 8'h21);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("p0_out", {2'h0, p0_out}, 8'h21);
		// flag rises regardless; masking it is software's job upstream
		chk("p0_irq_flag", {2'h0, p0_irq_flag}, 8'h21);
		wr(iop_pkg::OFS_P0FLAG, 8'h01);
		rd(iop_pkg::OFS_P0FLAG, 8'h20);
		// key-return enabled by the expansion register, four pins first
		wr(iop_pkg::OFS_MEMX, iop_pkg::MEMX_KR_ON);
		wr(iop_pkg::OFS_KRSW, 8'h00);
		fall(8'hdf, 1'h0);
		fall(8'hfe, 1'h1);
		rd(iop_pkg::OFS_KRFLAG, 8'h01);
		wr(iop_pkg::OFS_KRFLAG, 8'h01);
		rd(iop_pkg::OFS_KRFLAG, 8'h00);
		wr(iop_pkg::OFS_KRSW, 8'h01);
		rd(iop_pkg::OFS_KRSW, 8'h01);
		fall(8'hdf, 1'h1);
		wr(iop_pkg::OFS_MEMX, 8'h00);
		wr(iop_pkg::OFS_KRFLAG, 8'h01);
		fall(8'hfe, 1'h0);
		complete_run();
	end
endmodule // iop_io_port_bank_test
